// File: src/cix_pkg.sv
// constants for the instruction execution subset
// assumes a 14-bit instruction word and a 13-bit program counter
package cix_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int CALL_K_W = 11;
  // opcode fields and values
  localparam int OP_HI = 13;
  localparam int OP6_LO = 8;
  localparam int OP3_LO = 11;
  localparam int DEST_BIT = 7;
  localparam int BITSEL_HI = 9;
  localparam int BITSEL_LO = 7;
  localparam logic [5:0] OP6_AND_LIT = 6'h39;
  localparam logic [5:0] OP6_AND_FILE = 6'h05;
  localparam logic [5:0] OP6_COMPLEMENT_FILE_OP = 6'h09;
  localparam logic [3:0] OP4_SKIP_CLR = 4'h6;
  localparam logic [3:0] OP4_SKIP_SET = 4'h7;
  localparam logic [2:0] OP3_CALL = 3'h4;
  localparam logic [13:0] INSTR_WDT_CLEAR = 14'h0064;
  // high latch bits that feed pc 12:11
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  // reset values
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic POWERDOWN_RESET = 1'b1;
  localparam logic [7:0] WDT_CLEAR_VALUE = 8'h00;
  // alu operation select
  typedef enum logic [1:0] {
    CIX_ALU_PASS = 2'b00,
    CIX_ALU_AND_LIT = 2'b01,
    CIX_ALU_AND_FILE = 2'b11,
    CIX_ALU_COMPLEMENT_FILE_OP = 2'b10
  } cix_alu_e;
  // gray coded sequencer states
  typedef enum logic [1:0] {
    CIX_EXEC = 2'b00,
    CIX_SKIP = 2'b01,
    CIX_CALL = 2'b10
  } cix_state_e;
endpackage

// File: src/cix_alu.sv
// byte logic unit for the and / complement operations
// assumes operands are stable within the cycle; purely combinational
module cix_alu
  import cix_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire cix_alu_e op,
  input wire logic [WIDTH-1:0] acc,
  input wire logic [WIDTH-1:0] lit,
  input wire logic [WIDTH-1:0] fdata,
  output logic [WIDTH-1:0] result,
  output logic zero
);
  always_comb begin
    unique case (op)
      CIX_ALU_AND_LIT: result = acc & lit;
      CIX_ALU_AND_FILE: result = acc & fdata;
      CIX_ALU_COMPLEMENT_FILE_OP: result = ~fdata;
      CIX_ALU_PASS: result = acc;
    endcase
  end

  assign zero = (result == '0);
endmodule

// File: src/cix_core.sv
// executes the and, complement, bit-test skip, watchdog clear and call
// instructions of an 8-bit core.
// assumes the instruction at pc and the addressed file register byte
// arrive combinationally on the same clock; no synchroniser is needed.
module cix_core
  import cix_pkg::*;
#(
  parameter int PCW = PC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic [DATA_W-1:0] pc_high_latch,
  output logic [PCW-1:0] pc,
  output logic [DATA_W-1:0] acc,
  output logic zero_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic file_we,
  output logic [FADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  output logic stack_push,
  output logic [PCW-1:0] stack_top,
  output logic watchdog_clear,
  output logic prescaler_clear,
  output logic [DATA_W-1:0] watchdog_counter_load
);
  cix_state_e state;
  cix_state_e next_state;

  // decode
  wire logic [5:0] op6 = instr[OP_HI:OP6_LO];
  wire logic [3:0] op4 = instr[OP_HI:OP_HI-3];
  wire logic [2:0] op3 = instr[OP_HI:OP3_LO];
  wire logic in_exec = (state == CIX_EXEC);
  wire logic is_and_lit = in_exec && op6 == OP6_AND_LIT;
  wire logic is_and_file = in_exec && op6 == OP6_AND_FILE;
  wire logic is_complement_file_op = in_exec && op6 == OP6_COMPLEMENT_FILE_OP;
  wire logic is_skip_clr = in_exec && op4 == OP4_SKIP_CLR;
  wire logic is_skip_set = in_exec && op4 == OP4_SKIP_SET;
  wire logic is_wdt = in_exec && instr == INSTR_WDT_CLEAR;
  wire logic is_call = in_exec && op3 == OP3_CALL;
  wire logic dest_file = instr[DEST_BIT];
  wire logic [FADDR_W-1:0] faddr = instr[FADDR_W-1:0];
  wire logic [2:0] bit_sel = instr[BITSEL_HI:BITSEL_LO];
  wire logic tested_bit = file_rdata[bit_sel];
  wire logic skip_taken = (is_skip_clr && !tested_bit) ||
                          (is_skip_set && tested_bit);
  wire logic file_op = is_and_file || is_complement_file_op;
  wire logic zero_op = is_and_lit || file_op;

  wire cix_alu_e alu_op = is_and_lit ? CIX_ALU_AND_LIT :
                          is_and_file ? CIX_ALU_AND_FILE :
                          is_complement_file_op ? CIX_ALU_COMPLEMENT_FILE_OP : CIX_ALU_PASS;
  wire logic [DATA_W-1:0] alu_result;
  wire logic alu_zero;

  cix_alu #(.WIDTH(DATA_W)) u_alu (
    .op(alu_op),
    .acc(acc),
    .lit(instr[DATA_W-1:0]),
    .fdata(file_rdata),
    .result(alu_result),
    .zero(alu_zero)
  );

  wire logic [PCW-1:0] pc_inc = pc + PCW'(1);
  wire logic [PCW-1:0] call_target = PCW'({pc_high_latch[LATCH_HI:LATCH_LO],
                                           instr[CALL_K_W-1:0]});
  // call slot holds pc; the skip slot still steps past the dead word
  wire logic [PCW-1:0] next_pc = is_call ? call_target :
                                 (state == CIX_CALL) ? pc :
                                 pc_inc;
  wire logic acc_we = is_and_lit || (file_op && !dest_file);
  wire logic next_file_we = file_op && dest_file;

  always_comb begin
    unique case (state)
      CIX_EXEC: next_state = is_call ? CIX_CALL :
                             skip_taken ? CIX_SKIP : CIX_EXEC;
      CIX_SKIP: next_state = CIX_EXEC;
      CIX_CALL: next_state = CIX_EXEC;
      default: next_state = CIX_EXEC;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CIX_EXEC;
      pc <= PC_RESET;
    end else begin
      state <= next_state;
      pc <= next_pc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= W_RESET;
      zero_flag <= 1'b0;
    end else begin
      if (acc_we) acc <= alu_result;
      if (zero_op) zero_flag <= alu_zero;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_we <= 1'b0;
      file_waddr <= '0;
      file_wdata <= '0;
    end else begin
      file_we <= next_file_we;
      file_waddr <= faddr;
      file_wdata <= alu_result;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag <= TIMEOUT_RESET;
      powerdown_flag <= POWERDOWN_RESET;
      watchdog_clear <= 1'b0;
      prescaler_clear <= 1'b0;
      watchdog_counter_load <= WDT_CLEAR_VALUE;
    end else begin
      if (is_wdt) timeout_flag <= 1'b1;
      if (is_wdt) powerdown_flag <= 1'b1;
      watchdog_clear <= is_wdt;
      prescaler_clear <= is_wdt;
      watchdog_counter_load <= WDT_CLEAR_VALUE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_push <= 1'b0;
      stack_top <= '0;
    end else begin
      stack_push <= is_call;
      if (is_call) stack_top <= pc_inc;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  and_lit_acc_a: assert property (is_and_lit |=>
    acc == ($past(acc) & $past(instr[7:0])))
    else $error("literal and gave wrong accumulator");
  skip_clr_slot_a: assert property (
    is_skip_clr && !tested_bit |=> state == CIX_SKIP ##1 state == CIX_EXEC)
    else $error("skip-if-clear did not take the nop slot");
  skip_clr_none_a: assert property (is_skip_clr && tested_bit |=>
    state == CIX_EXEC)
    else $error("skip-if-clear skipped on a set bit");
  skip_set_slot_a: assert property (
    is_skip_set && tested_bit |=> state == CIX_SKIP ##1 state == CIX_EXEC)
    else $error("skip-if-set did not take the nop slot");
  skip_set_none_a: assert property (
    is_skip_set && !tested_bit |=> state == CIX_EXEC)
    else $error("skip-if-set skipped on a clear bit");
  file_and_dest_a: assert property (
    is_and_file && dest_file |=> file_we &&
    file_wdata == ($past(acc) & $past(file_rdata)) && $stable(acc))
    else $error("file and to file went wrong");
  dest_acc_a: assert property (file_op && !dest_file |=>
    !file_we && acc == $past(alu_result))
    else $error("destination 0 did not land in accumulator");
  complement_file_op_result_a: assert property (is_complement_file_op && !dest_file |=>
    acc == ~$past(file_rdata))
    else $error("complement result wrong");
  zero_flag_a: assert property (zero_op |=>
    zero_flag == ($past(alu_result) == 8'h00))
    else $error("zero flag does not match result");
  wdt_flags_a: assert property (is_wdt |=>
    timeout_flag && powerdown_flag && watchdog_clear && prescaler_clear &&
    $stable(zero_flag))
    else $error("watchdog clear effects missing");
  wdt_load_a: assert property (watchdog_clear |->
    watchdog_counter_load == 8'h00)
    else $error("watchdog load value not zero");
  call_push_a: assert property (is_call |=>
    stack_push && stack_top == $past(pc) + 13'h0001)
    else $error("call pushed wrong return address");
  call_pc_a: assert property (is_call |=>
    pc == {$past(pc_high_latch[4:3]), $past(instr[10:0])} ##1
    $stable(pc) && state == CIX_EXEC)
    else $error("call target or two-cycle timing wrong");
  call_low_a: assert property (is_call |=>
    pc[10:0] == $past(instr[10:0]))
    else $error("call target low bits wrong");
  call_flags_a: assert property (is_call |=> $stable(zero_flag)
    && $stable(timeout_flag) ##1 $stable(zero_flag))
    else $error("call changed a status flag");
  skip_quiet_a: assert property (state == CIX_SKIP |=>
    !file_we && !stack_push && !watchdog_clear && $stable(acc) &&
    $stable(zero_flag) && pc == $past(pc) + 13'h0001)
    else $error("discarded slot had a side effect");

  skip_taken_c: cover property (skip_taken ##1 state == CIX_SKIP);
  call_c: cover property (is_call ##2 state == CIX_EXEC);
  file_write_c: cover property (next_file_we);
  wdt_c: cover property (is_wdt);
  skip_set_c: cover property (is_skip_set && tested_bit);
endmodule

// File: verification/tb_cpu_instruction_exec_subset.sv
// self-checking bench for the instruction execution subset
// assumes cix_core alone, inputs driven 1 ns after each rising edge
module tb_cpu_instruction_exec_subset
  import cix_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] pc_high_latch = 8'h00;
  logic [12:0] pc, stack_top, e_pc, e_top;
  logic [7:0] acc, file_wdata, watchdog_counter_load, e_acc, e_wd;
  logic [6:0] file_waddr, e_wa;
  logic zero_flag, timeout_flag, powerdown_flag, file_we, stack_push;
  logic watchdog_clear, prescaler_clear, e_z, e_we, e_push, e_wdc;
  logic [1:0] st;
  logic [31:0] r;
  logic [13:0] w;
  int mismatches = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  cix_core uut (.clk(clk), .rst_n(rst_n), .instr(instr),
    .file_rdata(file_rdata), .pc_high_latch(pc_high_latch), .pc(pc),
    .acc(acc), .zero_flag(zero_flag), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata),
    .stack_push(stack_push), .stack_top(stack_top),
    .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear),
    .watchdog_counter_load(watchdog_counter_load));
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (e !== g) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_all;
    chk("pc", e_pc, pc);
    chk("acc", e_acc, acc);
    chk("zero_flag", e_z, zero_flag);
    chk("file_we", e_we, file_we);
    if (e_we) begin
      chk("file_waddr", e_wa, file_waddr);
      chk("file_wdata", e_wd, file_wdata);
    end
    chk("stack_push", e_push, stack_push);
    chk("stack_top", e_top, stack_top);
    chk("watchdog_clear", e_wdc, watchdog_clear);
    chk("prescaler_clear", e_wdc, prescaler_clear);
    chk("wd_load", 8'h00, watchdog_counter_load);
    chk("timeout_flag", 1'b1, timeout_flag);
    chk("powerdown_flag", 1'b1, powerdown_flag);
  endtask
  // reference model: st 0 execute, 1 discarded slot, 2 call second cycle
  task automatic step(input logic [13:0] i, input logic [7:0] f, l);
    logic [7:0] res;
    logic b;
    instr = i;
    file_rdata = f;
    pc_high_latch = l;
    {e_we, e_push, e_wdc} = 3'b000;
    b = f[i[9:7]];
    if (st != 2'd0) begin
      if (st == 2'd1) e_pc = e_pc + 13'h0001;
      st = 2'd0;
    end else begin
      e_pc = e_pc + 13'h0001;
      if (i[13:8] == OP6_AND_LIT) begin
        e_acc = e_acc & i[7:0];
        e_z = (e_acc == 8'h00);
      end else if (i[13:8] == OP6_AND_FILE || i[13:8] == OP6_COMPLEMENT_FILE_OP) begin
        res = (i[13:8] == OP6_COMPLEMENT_FILE_OP) ? ~f : (e_acc & f);
        e_z = (res == 8'h00);
        if (i[7]) begin
          e_we = 1'b1;
          e_wa = i[6:0];
          e_wd = res;
        end else e_acc = res;
      end else if (i[13:10] == OP4_SKIP_CLR) begin
        st = b ? 2'd0 : 2'd1;
      end else if (i[13:10] == OP4_SKIP_SET) begin
        st = b ? 2'd1 : 2'd0;
      end else if (i[13:11] == OP3_CALL) begin
        e_push = 1'b1;
        e_top = e_pc;
        e_pc = {l[4:3], i[10:0]};
        st = 2'd2;
      end else if (i == INSTR_WDT_CLEAR) e_wdc = 1'b1;
    end
  endtask
  task automatic cyc(input logic [13:0] i, input logic [7:0] f, l);
    step(i, f, l);
    @(posedge clk);
    #1;
    check_all();
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hefa7));
    {e_pc, e_top, e_acc, e_z, e_we, e_push, e_wdc, st} = '0;
    repeat (5) @(posedge clk);
    #1;
    check_all();
    rst_n = 1'b1;
    // corners: zero results, top bit and address, skips hiding side effects
    cyc({OP6_COMPLEMENT_FILE_OP, 1'b0, 7'h7f}, 8'h5a, 8'h00);
    cyc({OP6_AND_LIT, 8'h00}, 8'hff, 8'h00);
    cyc({OP6_COMPLEMENT_FILE_OP, 1'b1, 7'h7f}, 8'hff, 8'h00);
    cyc({OP4_SKIP_CLR, 3'd7, 7'h7f}, 8'h7f, 8'h00);
    cyc({OP3_CALL, 11'h7ff}, 8'h00, 8'h18);
    cyc({OP4_SKIP_SET, 3'd0, 7'h00}, 8'h01, 8'h00);
    cyc(INSTR_WDT_CLEAR, 8'h00, 8'h00);
    cyc({OP3_CALL, 11'h7ff}, 8'h00, 8'h18);
    cyc({OP6_AND_FILE, 1'b1, 7'h00}, 8'h00, 8'hff);
    cyc(INSTR_WDT_CLEAR, 8'h00, 8'h00);
    // random mix, about one word in eight arbitrary to exercise nop decoding
    repeat (3000) begin
      r = $urandom;
      case (r[31:29])
        3'd0: w = {OP6_AND_LIT, r[7:0]};
        3'd1: w = {OP6_AND_FILE, r[7:0]};
        3'd2: w = {OP6_COMPLEMENT_FILE_OP, r[7:0]};
        3'd3: w = {OP4_SKIP_CLR, r[9:0]};
        3'd4: w = {OP4_SKIP_SET, r[9:0]};
        3'd5: w = {OP3_CALL, r[10:0]};
        3'd6: w = INSTR_WDT_CLEAR;
        default: w = r[13:0];
      endcase
      cyc(w, r[27:20], r[19:12]);
    end
    tally_and_finish();
  end
endmodule
